// ===== hw/board_ctl_stat_regs.sv
// What this block does
// - SMBus slave at 0x5c, command-code decode
// - Control written at a0, read a1, resets 0
// - Bit 7 lights green general LED
// - Bit 6 disables handle switch
// - Bit 5 selects switch power event/reset
// - Bits 4:3 pick watchdog time-out
// - Retrigger bit change restarts watchdog count
// - Watchdog idle after reset, armed first edge
// - Bit 1 blinks red power LED
// - Bit 0 requests full system reset
// - First status read b1, cleared b0
// - First status rail fail bits, 4,1 zero
// - First status sticky, any write clears
// - Second status read b3, cleared b2
// - Status bit 7 shows watchdog armed
// - Status bit 6 marks watchdog reset cause
// - Status bit 5 shows half time elapsed
// - Status bits 4:0 flag rail failures
// - Second status sticky except live bits
// - Revision read at c1, never written
`include "board_ctl_stat_defines.svh"
`default_nettype none
module board_ctl_stat_regs #(
    parameter int unsigned TICK_CYCLES = `BCS_TICK_MS * (`BCS_SYS_CLK_HZ / 1000)
) (
    input wire logic sys_clk, // system clock, 10 MHz
    input wire logic arst_n, // power-on reset, async, active low
    input wire logic smb_clk, // free-running bus sampling clock
    input wire logic scl_i, // bus clock pin level
    input wire logic sda_i, // bus data pin level
    output logic sda_o, // bus data drive value, always low
    output logic sda_oe, // bus data pulled low while high
    input wire board_ctl_stat_pkg::pin_bundle_t pins_i, // switch, reset, rail pins
    output logic led_green, // general LED green element
    output logic led_red, // power LED red element
    output logic power_event, // handle switch power event
    output logic switch_reset, // handle switch system reset
    output logic full_reset_req // full system reset request
);
    import board_ctl_stat_pkg::*;

    // ------------------------------------------------------------------------
    // Link side: bus pin sampling
    // ------------------------------------------------------------------------
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic rd_ack_s1, rd_ack_s2, rd_ack_s3;
    logic rd_ack_tgl_r;
    logic [7:0] rd_data_r;

    always_ff @(posedge smb_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            {rd_ack_s1, rd_ack_s2, rd_ack_s3} <= 3'h0;
        end
        else
        begin
            {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
            {rd_ack_s1, rd_ack_s2, rd_ack_s3} <= {rd_ack_tgl_r, rd_ack_s1, rd_ack_s2};
        end
    end

    wire logic scl_rise = scl_s2 & ~scl_s3;
    wire logic scl_fall = ~scl_s2 & scl_s3;
    wire logic bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    wire logic bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    wire logic rd_ack_evt = rd_ack_s2 ^ rd_ack_s3;
    wire logic [7:0] own_addr = `BCS_SMB_ADDR;

    // ------------------------------------------------------------------------
    // Link side: slave state machine
    // ------------------------------------------------------------------------
    smb_state_t state_r, state_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic read_r, read_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    reg_write_t wr_r, wr_nxt;
    logic wr_tgl_r, wr_tgl_nxt;
    logic rd_tgl_r, rd_tgl_nxt;
    logic [7:0] rd_link_r, rd_link_nxt;
    logic sda_oe_r, sda_oe_nxt;

    always_comb
    begin
        state_nxt = state_r;
        bit_nxt = bit_r;
        shift_nxt = shift_r;
        idx_nxt = idx_r;
        read_nxt = read_r;
        cmd_nxt = cmd_r;
        wr_nxt = wr_r;
        wr_tgl_nxt = wr_tgl_r;
        rd_tgl_nxt = rd_tgl_r;
        // The host answer word is stable once its toggle is seen here.
        rd_link_nxt = rd_ack_evt ? rd_data_r : rd_link_r;
        unique case (state_r)
            S_IDLE:
            begin
            end
            S_RX:
            begin
                if (scl_rise)
                begin
                    shift_nxt = {shift_r[6:0], sda_s2};
                    bit_nxt = bit_r + 4'h1;
                end
                else if (scl_fall && bit_r == 4'h8)
                begin
                    bit_nxt = 4'h0;
                    state_nxt = S_ACK;
                    unique case (idx_r)
                        2'h0:
                        begin
                            if (shift_r[7:1] != own_addr[7:1])
                                state_nxt = S_IDLE;
                            read_nxt = shift_r[0];
                        end
                        2'h1:
                        begin
                            cmd_nxt = shift_r;
                            rd_tgl_nxt = ~rd_tgl_r;
                        end
                        2'h2:
                        begin
                            wr_nxt = '{cmd: cmd_r, data: shift_r};
                            wr_tgl_nxt = ~wr_tgl_r;
                        end
                        2'h3:
                        begin
                            // Bytes past a Byte Data write are refused.
                            state_nxt = S_IDLE;
                        end
                    endcase
                end
            end
            S_ACK:
            begin
                if (scl_fall)
                begin
                    idx_nxt = idx_r + 2'h1;
                    if (read_r && idx_r == 2'h0)
                    begin
                        state_nxt = S_TX;
                        shift_nxt = rd_link_r;
                    end
                    else
                        state_nxt = S_RX;
                end
            end
            S_TX:
            begin
                if (scl_fall)
                begin
                    shift_nxt = {shift_r[6:0], 1'h1};
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == 4'h7)
                    begin
                        bit_nxt = 4'h0;
                        state_nxt = S_HACK;
                    end
                end
            end
            S_HACK:
            begin
                // One byte per read; the host ends with stop or restart.
                if (scl_fall)
                    state_nxt = S_IDLE;
            end
            default:
                state_nxt = S_IDLE;
        endcase
        if (bus_start)
        begin
            state_nxt = S_RX;
            bit_nxt = 4'h0;
            idx_nxt = 2'h0;
        end
        else if (bus_stop)
            state_nxt = S_IDLE;
        sda_oe_nxt = (state_nxt == S_ACK) || (state_nxt == S_TX && !shift_nxt[7]);
    end

    always_ff @(posedge smb_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= S_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            idx_r <= 2'h0;
            read_r <= 1'h0;
            cmd_r <= 8'h00;
            wr_r <= '0;
            wr_tgl_r <= 1'h0;
            rd_tgl_r <= 1'h0;
            rd_link_r <= 8'h00;
            sda_oe_r <= 1'h0;
        end
        else
        begin
            state_r <= state_nxt;
            bit_r <= bit_nxt;
            shift_r <= shift_nxt;
            idx_r <= idx_nxt;
            read_r <= read_nxt;
            cmd_r <= cmd_nxt;
            wr_r <= wr_nxt;
            wr_tgl_r <= wr_tgl_nxt;
            rd_tgl_r <= rd_tgl_nxt;
            rd_link_r <= rd_link_nxt;
            sda_oe_r <= sda_oe_nxt;
        end
    end

    assign sda_o = 1'h0;
    assign sda_oe = sda_oe_r;

    // ------------------------------------------------------------------------
    // System side: synchronisers
    // ------------------------------------------------------------------------
    pin_bundle_t pin_s1, pin_s2;
    logic wr_s1, wr_s2, wr_s3;
    logic rd_s1, rd_s2, rd_s3;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            {wr_s1, wr_s2, wr_s3} <= 3'h0;
            {rd_s1, rd_s2, rd_s3} <= 3'h0;
        end
        else
        begin
            pin_s1 <= pins_i;
            pin_s2 <= pin_s1;
            {wr_s1, wr_s2, wr_s3} <= {wr_tgl_r, wr_s1, wr_s2};
            {rd_s1, rd_s2, rd_s3} <= {rd_tgl_r, rd_s1, rd_s2};
        end
    end

    // ------------------------------------------------------------------------
    // System side: decode
    // ------------------------------------------------------------------------
    // The link holds wr_r and cmd_r for a whole byte time after each toggle,
    // far longer than the three system cycles needed to see it.
    wire logic wr_evt = wr_s2 ^ wr_s3;
    wire logic rd_evt = rd_s2 ^ rd_s3;
    wire logic board_rst = ~pin_s2.board_rst_n;
    wire logic ctrl_wr = wr_evt && wr_r.cmd == `BCS_CMD_CTRL_WR;
    wire logic clr_pf = wr_evt && wr_r.cmd == `BCS_CMD_PF_CLR;
    wire logic clr_wr = wr_evt && wr_r.cmd == `BCS_CMD_WR_CLR;
    wire control_register_t ctrl_new = control_register_t'(wr_r.data);

    control_register_t ctrl_r, ctrl_nxt;
    assign ctrl_nxt = board_rst ? control_register_t'(`BCS_CTRL_RESET)
                    : ctrl_wr ? ctrl_new : ctrl_r;

    // ------------------------------------------------------------------------
    // System side: time base and blink
    // ------------------------------------------------------------------------
    localparam logic [3:0] BLINK_TICKS = 4'(`BCS_BLINK_HALF_MS / `BCS_TICK_MS);
    localparam logic [11:0] WDT_LOAD0 = 12'(`BCS_WDT_T0_S * 1000 / `BCS_TICK_MS);
    localparam logic [11:0] WDT_LOAD1 = 12'(`BCS_WDT_T1_S * 1000 / `BCS_TICK_MS);
    localparam logic [11:0] WDT_LOAD2 = 12'(`BCS_WDT_T2_S * 1000 / `BCS_TICK_MS);
    localparam logic [11:0] WDT_LOAD3 = 12'(`BCS_WDT_T3_S * 1000 / `BCS_TICK_MS);

    logic [19:0] tick_cnt_r;
    logic [3:0] blink_cnt_r;
    logic blink_r;
    wire logic tick = tick_cnt_r == 20'(TICK_CYCLES - 1);
    wire logic blink_flip = tick && blink_cnt_r == BLINK_TICKS - 4'h1;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_cnt_r <= 20'h0;
            blink_cnt_r <= 4'h0;
            blink_r <= 1'h0;
        end
        else
        begin
            tick_cnt_r <= tick ? 20'h0 : tick_cnt_r + 20'h1;
            blink_cnt_r <= blink_flip ? 4'h0 : tick ? blink_cnt_r + 4'h1 : blink_cnt_r;
            blink_r <= blink_flip ? ~blink_r : blink_r;
        end
    end

    // ------------------------------------------------------------------------
    // System side: watchdog
    // ------------------------------------------------------------------------
    // Pattern digits are read as bit 3 then bit 4.
    wire logic [11:0] wdt_load =
        (ctrl_new.watchdog_timeout_select == 2'h0) ? WDT_LOAD0 :
        (ctrl_new.watchdog_timeout_select == 2'h2) ? WDT_LOAD1 :
        (ctrl_new.watchdog_timeout_select == 2'h1) ? WDT_LOAD2 : WDT_LOAD3;
    wire logic retrig = ctrl_wr &&
        ctrl_new.watchdog_retrigger != ctrl_r.watchdog_retrigger;

    logic armed_r, armed_nxt;
    logic fire_r, fire_nxt;
    logic [11:0] wdt_cnt_r, wdt_cnt_nxt;
    logic [11:0] wdt_half_r, wdt_half_nxt;
    wire logic expire = armed_r && tick && wdt_cnt_r == 12'h1;

    always_comb
    begin
        armed_nxt = armed_r;
        fire_nxt = fire_r;
        wdt_cnt_nxt = wdt_cnt_r;
        wdt_half_nxt = wdt_half_r;
        if (board_rst)
        begin
            armed_nxt = 1'h0;
            fire_nxt = 1'h0;
            wdt_cnt_nxt = 12'h0;
        end
        else if (retrig)
        begin
            armed_nxt = 1'h1;
            wdt_cnt_nxt = wdt_load;
            wdt_half_nxt = {1'h0, wdt_load[11:1]};
        end
        else if (expire)
        begin
            armed_nxt = 1'h0;
            fire_nxt = 1'h1;
            wdt_cnt_nxt = 12'h0;
        end
        else if (armed_r && tick)
            wdt_cnt_nxt = wdt_cnt_r - 12'h1;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_r <= control_register_t'(`BCS_CTRL_RESET);
            armed_r <= 1'h0;
            fire_r <= 1'h0;
            wdt_cnt_r <= 12'h0;
            wdt_half_r <= 12'h0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            armed_r <= armed_nxt;
            fire_r <= fire_nxt;
            wdt_cnt_r <= wdt_cnt_nxt;
            wdt_half_r <= wdt_half_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // System side: sticky cause flags
    // ------------------------------------------------------------------------
    // Only the power-on reset and the clear commands clear these, so they survive a board reset.
    localparam int NPF = PG0_W + PG1_W;
    logic [NPF-1:0] pf_r, pf_nxt, pg_prev_r;
    wire logic [NPF-1:0] pg_now = {pin_s2.pg1, pin_s2.pg0};
    logic cause_r;
    wire logic cause_nxt = fire_nxt & ~fire_r | (cause_r & ~clr_wr);

    for (genvar i = 0; i < NPF; i++)
    begin : g_rail
        wire logic clr_i = (i < PG0_W) ? clr_pf : clr_wr;
        // A failure in the clearing cycle still sets the flag.
        assign pf_nxt[i] = (pg_prev_r[i] & ~pg_now[i] & pin_s2.rails_expected)
                         | (pf_r[i] & ~clr_i);
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pf_r <= '0;
            pg_prev_r <= '1;
            cause_r <= 1'h0;
        end
        else
        begin
            pf_r <= pf_nxt;
            pg_prev_r <= pg_now;
            cause_r <= cause_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // System side: read data
    // ------------------------------------------------------------------------
    wire power_fail_status_t stat0 = '{
        fail_1v8_standby: pf_r[5],
        fail_1v5_standby: pf_r[4],
        fail_1v35_standby: pf_r[3],
        rsvd_4: 1'h0,
        fail_1v05_main: pf_r[2],
        fail_1v05_standby: pf_r[1],
        rsvd_1: 1'h0,
        fail_core_regulator: pf_r[0]
    };
    wire watchdog_rail_status_t stat1 = '{
        watchdog_armed_flag: armed_r,
        watchdog_reset_cause: cause_r,
        watchdog_half_elapsed: armed_r && wdt_cnt_r <= wdt_half_r,
        fail_12v_rail: pf_r[10],
        fail_5v_standby: pf_r[9],
        fail_3v3_main: pf_r[8],
        fail_3v3_aux: pf_r[7],
        fail_3v3_standby: pf_r[6]
    };
    wire logic [7:0] rd_sel =
        (cmd_r == `BCS_CMD_CTRL_RD) ? ctrl_r :
        (cmd_r == `BCS_CMD_PF_RD) ? stat0 :
        (cmd_r == `BCS_CMD_WR_RD) ? stat1 :
        (cmd_r == `BCS_CMD_REV_RD) ? `BCS_LOGIC_REV : `BCS_NO_DATA;

    // ------------------------------------------------------------------------
    // System side: outputs
    // ------------------------------------------------------------------------
    wire logic sw_on = ~pin_s2.handle_sw_n & ~ctrl_r.handle_switch_disable;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_data_r <= 8'h00;
            rd_ack_tgl_r <= 1'h0;
            led_green <= 1'h0;
            led_red <= 1'h0;
            power_event <= 1'h0;
            switch_reset <= 1'h0;
            full_reset_req <= 1'h0;
        end
        else
        begin
            rd_data_r <= rd_evt ? rd_sel : rd_data_r;
            rd_ack_tgl_r <= rd_ack_tgl_r ^ rd_evt;
            led_green <= ctrl_r.general_led_green;
            led_red <= ctrl_r.power_led_red_blink & blink_r;
            power_event <= sw_on & ~ctrl_r.handle_switch_reset_select;
            switch_reset <= sw_on & ctrl_r.handle_switch_reset_select;
            full_reset_req <= ctrl_r.full_reset_request | fire_r;
        end
    end

endmodule : board_ctl_stat_regs
`default_nettype wire

// ===== hw/board_ctl_stat_defines.svh
`ifndef BOARD_CTL_STAT_DEFINES_SVH
`define BOARD_CTL_STAT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Bus address and command codes
// ----------------------------------------------------------------------------
`define BCS_SMB_ADDR 8'h5c
`define BCS_CMD_CTRL_WR 8'ha0
`define BCS_CMD_CTRL_RD 8'ha1
`define BCS_CMD_PF_CLR 8'hb0
`define BCS_CMD_PF_RD 8'hb1
`define BCS_CMD_WR_CLR 8'hb2
`define BCS_CMD_WR_RD 8'hb3
`define BCS_CMD_REV_RD 8'hc1

// ----------------------------------------------------------------------------
// Reset and read values
// ----------------------------------------------------------------------------
`define BCS_CTRL_RESET 8'h00
`define BCS_NO_DATA 8'h00
// Arbitrary revision value.
`define BCS_LOGIC_REV 8'h01

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BCS_SYS_CLK_HZ 10000000
`define BCS_TICK_MS 100
`define BCS_BLINK_HALF_MS 500
`define BCS_WDT_T0_S 2
`define BCS_WDT_T1_S 10
`define BCS_WDT_T2_S 50
`define BCS_WDT_T3_S 250

`endif

// ===== hw/board_ctl_stat_pkg.sv
`default_nettype none
package board_ctl_stat_pkg;

    localparam int PG0_W = 6;
    localparam int PG1_W = 5;

    typedef struct packed {
        logic general_led_green;
        logic handle_switch_disable;
        logic handle_switch_reset_select;
        logic [1:0] watchdog_timeout_select;
        logic watchdog_retrigger;
        logic power_led_red_blink;
        logic full_reset_request;
    } control_register_t;

    typedef struct packed {
        logic fail_1v8_standby;
        logic fail_1v5_standby;
        logic fail_1v35_standby;
        logic rsvd_4;
        logic fail_1v05_main;
        logic fail_1v05_standby;
        logic rsvd_1;
        logic fail_core_regulator;
    } power_fail_status_t;

    typedef struct packed {
        logic watchdog_armed_flag;
        logic watchdog_reset_cause;
        logic watchdog_half_elapsed;
        logic fail_12v_rail;
        logic fail_5v_standby;
        logic fail_3v3_main;
        logic fail_3v3_aux;
        logic fail_3v3_standby;
    } watchdog_rail_status_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        logic handle_sw_n;
        logic board_rst_n;
        logic rails_expected;
        logic [PG1_W-1:0] pg1;
        logic [PG0_W-1:0] pg0;
    } pin_bundle_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RX   = 5'b00010,
        S_ACK  = 5'b00100,
        S_TX   = 5'b01000,
        S_HACK = 5'b10000
    } smb_state_t;

endpackage : board_ctl_stat_pkg
`default_nettype wire

// ===== tb/board_ctl_stat_checker.sv
`default_nettype none
module board_ctl_stat_checker #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic sys_clk, // sys clock
    input wire logic arst_n, // reset
    input wire logic smb_clk, // bus clock
    input wire logic scl_i, // scl
    input wire logic sda_i, // sda
    input wire logic sda_o, // sda value
    input wire logic sda_oe, // sda pull
    input wire board_ctl_stat_pkg::pin_bundle_t pins_i, // pins
    input wire logic led_green, // led
    input wire logic led_red, // led
    input wire logic power_event, // event
    input wire logic switch_reset, // reset
    input wire logic full_reset_req // request
);
    timeunit 1ns;
    timeprecision 1ns;
    import board_ctl_stat_pkg::*;
    // Five samples cover the pin synchroniser and the output register.
    sequence brd_up;
        pins_i.board_rst_n [*5];
    endsequence
    sequence brd_down;
        !pins_i.board_rst_n [*5];
    endsequence
    full_req_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        brd_up ##0 full_reset_req |=> full_reset_req)
        else $error("reset request dropped");
    board_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        brd_down |=> !full_reset_req && !led_green && !led_red)
        else $error("board reset left outputs on");
    sw_exclusive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(power_event && switch_reset))
        else $error("switch drives both actions");
    sw_idle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pins_i.handle_sw_n [*5] |-> !power_event && !switch_reset)
        else $error("switch action without press");
    reset_quiet_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(arst_n) |-> !led_green && !led_red && !full_reset_req && !power_event)
        else $error("output active after reset");
    sda_const_a: assert property (@(posedge smb_clk) disable iff (!arst_n)
        sda_o == 1'b0)
        else $error("data drive value high");
    oe_scl_low_a: assert property (@(posedge smb_clk) disable iff (!arst_n)
        $changed(sda_oe) |-> !scl_i)
        else $error("data pull moved with clock high");
    oe_reset_a: assert property (@(posedge smb_clk) disable iff (!arst_n)
        $rose(arst_n) |-> !sda_oe)
        else $error("data pulled after reset");
endmodule : board_ctl_stat_checker

bind board_ctl_stat_regs board_ctl_stat_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .smb_clk(smb_clk), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .pins_i(pins_i), .led_green(led_green),
    .led_red(led_red), .power_event(power_event), .switch_reset(switch_reset),
    .full_reset_req(full_reset_req));
`default_nettype wire

// ===== tb/smbus_host_model.sv
`default_nettype none
module smbus_host_model (
    input wire logic smb_clk, // sampling clock
    input wire logic sda, // data line
    output logic scl, // clock line
    output logic sda_low // pulls data low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge smb_clk);
    endtask : wt
    // Data moves two edges after the clock fall, so no false START is seen.
    task automatic bx(input logic b, output logic r);
        wt(2);
        sda_low <= ~b;
        wt(5);
        scl <= 1'b1;
        wt(6);
        r = sda;
        scl <= 1'b0;
    endtask : bx
    task automatic st(input logic stop);
        wt(2);
        sda_low <= stop;
        wt(5);
        scl <= 1'b1;
        wt(5);
        sda_low <= ~stop;
        wt(5);
        if (!stop)
            scl <= 1'b0;
    endtask : st
    task automatic by(input logic [7:0] v, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            bx(v[i], q[i]);
        bx(1'b1, a);
    endtask : by
    task automatic xfer(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] dat,
        input logic rd, output logic [7:0] q, output logic ok);
        logic [7:0] j;
        logic a0, a1, a2, a3;
        st(1'b0);
        by(adr, j, a0);
        by(cmd, j, a1);
        if (rd)
        begin
            st(1'b0);
            by(adr | 8'h01, j, a2);
            by(8'hff, q, a3);
        end
        else
        begin
            by(dat, j, a2);
            q = 8'h00;
        end
        st(1'b1);
        ok = !(a0 | a1 | a2);
    endtask : xfer
endmodule : smbus_host_model
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
`include "board_ctl_stat_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import board_ctl_stat_pkg::*;
    localparam int unsigned TICKS = 200;
    logic sys_clk, smb_clk, arst_n, scl, host_low, sda_o, sda_oe, ok;
    logic led_green, led_red, power_event, switch_reset, full_reset_req;
    logic [7:0] q, d;
    pin_bundle_t pins;
    int error_cnt, tests_run, cyc, t0, seed;
    // The line is pulled up; any party pulling low wins.
    wire logic sda_w = ~(host_low | sda_oe);
    board_ctl_stat_regs #(.TICK_CYCLES(TICKS)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .smb_clk(smb_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .pins_i(pins), .led_green(led_green), .led_red(led_red), .power_event(power_event),
        .switch_reset(switch_reset), .full_reset_req(full_reset_req));
    smbus_host_model host_u (.smb_clk(smb_clk), .sda(sda_w), .scl(scl), .sda_low(host_low));
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial
    begin
        smb_clk = 1'b0;
        #13;
        forever #40 smb_clk = ~smb_clk;
    end
    function automatic logic [7:0] sw_exp(input logic [7:0] c, input logic n);
        return {6'h00, !n && !c[6] && !c[5], !n && !c[6] && c[5]};
    endfunction : sw_exp
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Only writable commands are written and only readable ones read.
    task automatic wr(input logic [7:0] c, input logic [7:0] v);
        host_u.xfer(8'h5c, c, v, 1'b0, q, ok);
        chk({7'h00, ok}, 8'h01);
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        host_u.xfer(8'h5c, c, 8'h00, 1'b1, q, ok);
        chk({7'h00, ok}, 8'h01);
        chk(q, e);
    endtask : rd
    task automatic brd();
        @(posedge sys_clk);
        pins.board_rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        pins.board_rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask : brd
    task automatic report_and_stop();
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial
    begin
        seed = 32'h21eb08b8;
        error_cnt = 0;
        tests_run = 0;
        cyc = 0;
        arst_n = 1'b0;
        pins = {1'b1, 1'b1, 1'b0, 5'h1f, 6'h3f};
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(8'ha1, 8'h00);
        rd(8'hb1, 8'h00);
        rd(8'hb3, 8'h00);
        rd(8'hc1, `BCS_LOGIC_REV);
        host_u.xfer(8'h58, 8'ha0, 8'h80, 1'b0, q, ok);
        chk({7'h00, ok}, 8'h00);
        rd(8'ha1, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 3) ? 8'hfa : ((8'($random(seed)) & 8'h9a) | {1'b0, i[1:0], 5'h00});
            @(posedge sys_clk);
            pins.handle_sw_n <= 1'($random(seed));
            wr(8'ha0, d);
            rd(8'ha1, d);
            chk({7'h00, led_green}, {7'h00, d[7]});
            chk({6'h00, power_event, switch_reset}, sw_exp(d, pins.handle_sw_n));
        end
        wr(8'ha0, 8'h02);
        @(posedge sys_clk);
        q = {7'h00, led_red};
        // The blink flips every five ticks, so 1000 cycles apart it must differ.
        repeat (1000) @(posedge sys_clk);
        chk({7'h00, led_red}, q ^ 8'h01);
        wr(8'ha0, 8'h01);
        repeat (20) @(posedge sys_clk);
        chk({7'h00, full_reset_req}, 8'h01);
        brd();
        chk({7'h00, full_reset_req}, 8'h00);
        rd(8'ha1, 8'h00);
        @(posedge sys_clk);
        pins.pg0[0] <= 1'b0;
        repeat (8) @(posedge sys_clk);
        pins.rails_expected <= 1'b1;
        repeat (8) @(posedge sys_clk);
        pins.pg0[5] <= 1'b0;
        pins.pg1[0] <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(8'hb1, 8'h80);
        rd(8'hb3, 8'h01);
        brd();
        rd(8'hb1, 8'h80);
        rd(8'hb3, 8'h01);
        wr(8'hb0, 8'h5a);
        rd(8'hb1, 8'h00);
        rd(8'hb3, 8'h01);
        wr(8'hb2, 8'ha5);
        rd(8'hb3, 8'h00);
        wr(8'ha0, 8'h04);
        t0 = cyc;
        rd(8'hb3, 8'h80);
        repeat (1800) @(posedge sys_clk);
        rd(8'hb3, 8'ha0);
        while (full_reset_req !== 1'b1 && cyc - t0 < 4500)
            @(posedge sys_clk);
        chk({7'h00, full_reset_req}, 8'h01);
        chk({7'h00, (cyc - t0) > 3700}, 8'h01);
        rd(8'hb3, 8'h40);
        brd();
        chk({7'h00, full_reset_req}, 8'h00);
        rd(8'hb3, 8'h40);
        wr(8'ha0, 8'h14);
        repeat (3000) @(posedge sys_clk);
        rd(8'hb3, 8'hc0);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
